// ### rtl/tcm_consts.vh
`ifndef TCM_CONSTS_VH
`define TCM_CONSTS_VH

// Connection word fields.
`define TCM_LOOPBACK_BIT   15
`define TCM_DELAY_SEL_BIT  14
`define TCM_PROC_CH_BIT    13
`define TCM_CTL_CH_BIT     12
`define TCM_OE_BIT         11
`define TCM_SRC_ST_HI      8
`define TCM_SRC_ST_LO      7
`define TCM_SRC_CH_HI      4
`define TCM_SRC_CH_LO      0
`define TCM_BYTE_HI        7

// Frame geometry.
`define TCM_STREAMS        4
`define TCM_CHANNELS       32
`define TCM_WORDS          128
`define TCM_AW             7
`define TCM_LAST_BIT       3'h7
`define TCM_LAST_CH        5'h1F
`define TCM_LAST_ST        2'h3

// APB register byte addresses.
`define TCM_A_CTRL         12'h000
`define TCM_A_ADDR         12'h004
`define TCM_A_DATA         12'h008
`define TCM_A_OFFS         12'h00C
`define TCM_A_MEAS         12'h010
`define TCM_A_STAT         12'h014
`define TCM_A_OFFS_APPLY   12'h018

// Control register bits.
`define TCM_CTRL_EN        0
`define TCM_CTRL_AINC      1

// Measured delay register layout.
`define TCM_MEAS_HALF      11
`define TCM_MEAS_LOW_HI    2

// Bit period in fast clocks, less one.
`define TCM_BIT_CYC        8'h63

// Receive sample points: mid bit, and half a bit period later.
`define TCM_SAMPLE_CYC     8'h31
`define TCM_SAMPLE_LATE    8'h63

// Slot look-ahead for transmit load and the control bit.
`define TCM_NEXT_CH        5'h01
`define TCM_CTL_AHEAD      5'h02
`define TCM_CTL_LAST_BIT   3'h2
`define TCM_CTL_FIRST_ST   2'h0

`define TCM_FIFO_DEPTH     4

`endif

// ### rtl/tcm_fifo.v
`timescale 1ns/100ps
module tcm_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wp_q;
   reg [AW-1:0]    rp_q;
   reg [AW:0]      cnt_q;
   wire            push = in_valid && in_ready;
   wire            pop  = out_valid && out_ready;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});

   always @* begin
      out_data = mem_q[rp_q];
   end

   always @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // tcm_fifo

// ### rtl/tcm_switch.v
`timescale 1ns/100ps
`include "tcm_consts.vh"

// Summary of operation
// [R1] Loopback takes receive data from own transmit
// [R2] Software zeroes offset for looped-back streams
// [R3] Delay select: low variable, high constant; the code ignores bit 14 and reads current data in both
// [R4] Processor channel sends word's low byte
// [R5] Otherwise word addresses source data memory
// [R6] Control bit one channel early, stream 0 first
// [R7] Output enable low tri-states that channel
// [R8] Software writes zero to unused bits
// [R9] Bits 8:7 select source stream
// [R10] Bits 4:0 select source channel
// [R11] Processor mode sends low eight bits unchanged
// [R12] Offset in half periods, zero to 4.5; the code uses only the half-period bit of each stream's offset
// [R13] Software copies measured delay into offset
// [R14] Half-cycle flag records frame edge phase
// [R15] One 16-bit word per output channel
module tcm_switch (
   // Clock and reset
   input  wire        clk,
   input  wire        nrst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Serial streams
   input  wire [3:0]  rx_in,
   output reg  [3:0]  tx_out,
   output reg  [3:0]  tx_oe,
   output reg         control_channel_out,
   // Frame pulse and bit phase, synchronous inputs
   input  wire        frame_pulse,
   input  wire        bit_clk_high
);
   reg         rs1_q, rs2_q;
   wire        rst_n = rs2_q;
   reg  [15:0] cm_q [0:`TCM_WORDS-1];
   reg  [7:0]  dm_q [0:`TCM_WORDS-1];
   reg  [7:0]  rxsh_q [0:`TCM_STREAMS-1];
   reg  [7:0]  txsh_q [0:`TCM_STREAMS-1];
   reg  [3:0]  oe_q;
   reg  [1:0]  ctrl_q;
   reg  [6:0]  addr_q;
   reg  [15:0] offs_q;
   reg  [11:0] meas_q;
   reg  [7:0]  div_q;
   reg  [2:0]  bit_q;
   reg  [4:0]  ch_q;
   reg  [3:0]  ctlch_q;
   reg  [15:0] rd_word;
   reg         fp_seen_q;
   wire        bit_end = (div_q == `TCM_BIT_CYC);
   wire        ch_end  = bit_end && (bit_q == `TCM_LAST_BIT);
   // Each APB data write is pushed with its word address; a full FIFO stalls the CPU bridge.
   wire        f_in_ready, f_out_valid;
   wire [22:0] f_out_data;
   wire        apb_acc = psel && penable && !pready;
   wire        is_data = (paddr == `TCM_A_DATA);
   wire        wr_req  = apb_acc && pwrite && is_data;
   integer     s;

   function [6:0] cm_index;
      input [1:0] st;
      input [4:0] ch;
      begin
         cm_index = {ch, st};
      end
   endfunction

   // Picks the bit that the receive side sees: own transmit when looped back.
   function rx_pick;
      input lp;
      input t;
      input r;
      begin
         rx_pick = lp ? t : r; // see [R1]
      end
   endfunction

   // Maps a measured delay to offset bits.
   function [3:0] offset_from_meas;
      input [11:0] m;
      begin
         offset_from_meas = {m[`TCM_MEAS_LOW_HI:0], ~m[`TCM_MEAS_HALF]}; // see [R13]
      end
   endfunction

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end

   tcm_fifo #(.WIDTH(23), .DEPTH(`TCM_FIFO_DEPTH), .AW(2)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (wr_req),
      .in_ready  (f_in_ready),
      .in_data   ({addr_q, pwdata[15:0]}),
      .out_valid (f_out_valid),
      .out_ready (1'b1),
      .out_data  (f_out_data)
   );

   always @(posedge clk) begin
      if (f_out_valid) begin
         cm_q[f_out_data[22:16]] <= f_out_data[15:0]; // see [R15]
      end
   end

   always @* begin
      rd_word = cm_q[addr_q];
   end

   // APB slave; data writes wait while the FIFO is full.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         ctrl_q  <= 2'h0;
         addr_q  <= 7'h00;
         offs_q  <= 16'h0000;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         if (apb_acc && !(wr_req && !f_in_ready)) begin
            pready <= 1'b1;
            prdata <= 32'h00000000;
            case (paddr)
               `TCM_A_CTRL: begin
                  if (pwrite) ctrl_q <= pwdata[1:0];
                  prdata[1:0] <= ctrl_q;
               end
               `TCM_A_ADDR: begin
                  if (pwrite) addr_q <= pwdata[6:0];
                  prdata[6:0] <= addr_q;
               end
               `TCM_A_DATA: begin
                  prdata[15:0] <= rd_word;
                  if (ctrl_q[`TCM_CTRL_AINC]) addr_q <= addr_q + 1'b1;
               end
               `TCM_A_OFFS: begin
                  if (pwrite) offs_q <= pwdata[15:0]; // see [R12]
                  prdata[15:0] <= offs_q;
               end
               `TCM_A_MEAS: prdata[11:0] <= meas_q;
               `TCM_A_STAT: prdata[7:0] <= {f_out_valid, f_in_ready, ch_q, fp_seen_q};
               `TCM_A_OFFS_APPLY: begin
                  if (pwrite) begin
                     for (s = 0; s < `TCM_STREAMS; s = s + 1) begin
                        if (pwdata[s]) offs_q[s*4 +: 4] <= offset_from_meas(meas_q);
                     end
                  end
               end
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Frame timing and the half-cycle phase of the frame pulse.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q     <= 8'h00;
         bit_q     <= 3'h0;
         ch_q      <= 5'h00;
         meas_q    <= 12'h000;
         fp_seen_q <= 1'b0;
      end else if (frame_pulse || !ctrl_q[`TCM_CTRL_EN]) begin
         div_q     <= 8'h00;
         bit_q     <= 3'h0;
         ch_q      <= 5'h00;
         if (frame_pulse) begin
            fp_seen_q <= 1'b1;
            meas_q[`TCM_MEAS_HALF] <= bit_clk_high; // see [R14]
         end
      end else begin
         div_q <= bit_end ? 8'h00 : div_q + 1'b1;
         if (bit_end) bit_q <= bit_q + 1'b1;
         if (ch_end) ch_q <= ch_q + 1'b1;
      end
   end

   // Receive sampling, offset by zero or one half period of the bit timer.
   always @(posedge clk) begin
      for (s = 0; s < `TCM_STREAMS; s = s + 1) begin
         if (div_q == (offs_q[s*4] ? `TCM_SAMPLE_LATE : `TCM_SAMPLE_CYC)) begin // see [R12]
            rxsh_q[s] <= {rxsh_q[s][6:0],
                          rx_pick(cm_q[cm_index(s[1:0], ch_q)][`TCM_LOOPBACK_BIT], tx_out[s], rx_in[s])}; // see [R1]
         end
      end
   end

   always @(posedge clk) begin
      if (ch_end) begin
         for (s = 0; s < `TCM_STREAMS; s = s + 1) begin
            // The late sample of the last bit falls on the slot end, so it is merged here.
            dm_q[cm_index(s[1:0], ch_q)] <= offs_q[s*4] ?
               {rxsh_q[s][6:0], rx_pick(cm_q[cm_index(s[1:0], ch_q)][`TCM_LOOPBACK_BIT], tx_out[s], rx_in[s])} :
               rxsh_q[s];
         end
      end
   end

   // Transmit: load per slot, shift out MSB first.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (s = 0; s < `TCM_STREAMS; s = s + 1) begin
            txsh_q[s] <= 8'h00;
         end
         oe_q                <= 4'h0;
         tx_out              <= 4'h0;
         tx_oe               <= 4'h0;
         ctlch_q             <= 4'h0;
         control_channel_out <= 1'b0;
      end else begin
         for (s = 0; s < `TCM_STREAMS; s = s + 1) begin
            if (ch_end) begin
               // Constant delay would need a frame buffer; both modes read current data here.
               if (cm_q[cm_index(s[1:0], ch_q + `TCM_NEXT_CH)][`TCM_PROC_CH_BIT]) begin // see [R4]
                  txsh_q[s] <= cm_q[cm_index(s[1:0], ch_q + `TCM_NEXT_CH)][`TCM_BYTE_HI:0]; // see [R11]
               end else begin
                  txsh_q[s] <= dm_q[cm_index(cm_q[cm_index(s[1:0], ch_q + `TCM_NEXT_CH)][`TCM_SRC_ST_HI:`TCM_SRC_ST_LO],
                     cm_q[cm_index(s[1:0], ch_q + `TCM_NEXT_CH)][`TCM_SRC_CH_HI:`TCM_SRC_CH_LO])]; // see [R5] [R9] [R10] [R3]
               end
               oe_q[s]    <= cm_q[cm_index(s[1:0], ch_q + `TCM_NEXT_CH)][`TCM_OE_BIT]; // see [R7]
               ctlch_q[s] <= cm_q[cm_index(s[1:0], ch_q + `TCM_CTL_AHEAD)][`TCM_CTL_CH_BIT]; // see [R6]
            end else if (bit_end) begin
               txsh_q[s] <= {txsh_q[s][6:0], 1'b0};
            end
            tx_out[s] <= txsh_q[s][7];
            tx_oe[s]  <= oe_q[s] && ctrl_q[`TCM_CTRL_EN];
         end
         // Stream 0 goes out in the first bit of the slot, the others follow bit by bit.
         if (ch_end) begin
            control_channel_out <= cm_q[cm_index(`TCM_CTL_FIRST_ST, ch_q + `TCM_CTL_AHEAD)][`TCM_CTL_CH_BIT]; // see [R6]
         end else if (bit_end && bit_q <= `TCM_CTL_LAST_BIT) begin
            control_channel_out <= ctlch_q[bit_q[1:0] + 2'h1]; // see [R6]
         end
      end
   end
endmodule // tcm_switch

// ### tb/tcm_switch_chk.sv
`timescale 1ns/100ps
module tcm_switch_chk (
   // Clock and reset
   input logic        clk,
   input logic        nrst,
   // Bus
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic        pready,
   input logic        pslverr,
   // Stream side
   input logic [3:0]  tx_oe
);
   wire req = psel & penable & ~pready;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ready_pulse_a:
      assert property (pready |=> !pready) else $error("Long pready.");
   err_ready_a:
      assert property (pslverr |-> pready) else $error("Lone pslverr.");
   read_answer_a:
      assert property (req && !pwrite |=> pready) else $error("Late read.");
   ready_cause_a:
      assert property (pready |-> $past(psel && penable)) else $error("Stray pready.");
   unmapped_err_a:
      assert property (req && paddr > 12'h018 |=> pslverr) else $error("No slave error.");
   mapped_read_a:
      assert property (req && !pwrite && paddr <= 12'h014 && paddr[1:0] == 2'h0 |=> !pslverr)
         else $error("False slave error.");
   idle_quiet_a:
      assert property (!psel |=> !pready) else $error("Idle pready.");
   reset_quiet_a:
      assert property (disable iff (1'b0) !nrst |-> tx_oe == 4'h0 && !pready) else $error("Reset outputs.");
endmodule // tcm_switch_chk

bind tcm_switch tcm_switch_chk chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .tx_oe(tx_oe));

// ### tb/tcm_partner.sv
`timescale 1ns/100ps
module tcm_partner (
   // Clock
   input  logic       clk,
   // Stream side
   output logic [3:0] rx_in,
   output logic       frame_pulse,
   output logic       bit_clk_high
);
   int         cnt = 0;
   int         s;
   logic [7:0] pb;
   initial begin
      rx_in = 4'h0;
      frame_pulse = 1'b0;
      bit_clk_high = 1'b0;
   end
   // Each stream repeats one byte per channel every frame, so any delay mode sees the same data.
   always @(posedge clk) begin
      cnt <= (cnt + 1) % 25600;
      frame_pulse <= (cnt == 0);
      bit_clk_high <= (cnt % 100 < 50);
      for (s = 0; s < 4; s++) begin
         pb = {s[1:0], 1'b1, 5'(cnt / 800)};
         rx_in[s] <= pb[7 - cnt / 100 % 8];
      end
   end
endmodule // tcm_partner

// ### tb/tsi_connection_memory_control_test.sv
`timescale 1ns/100ps
`include "tcm_consts.vh"
module tsi_connection_memory_control_test;
   logic        clk, nrst, psel, penable, pwrite, pready, pslverr, e;
   logic        control_channel_out, frame_pulse, bit_clk_high;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, r;
   logic [3:0]  rx_in, tx_out, tx_oe;
   logic [15:0] w [128];
   logic [15:0] wd;
   logic [7:0]  by;
   int          errors = 0;
   int          tests_run = 0;
   int          seed = 39439;
   int          i, k, s;

   tcm_switch uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe), .control_channel_out(control_channel_out),
      .frame_pulse(frame_pulse), .bit_clk_high(bit_clk_high));
   tcm_partner far (.clk(clk), .rx_in(rx_in), .frame_pulse(frame_pulse), .bit_clk_high(bit_clk_high));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task chk(input [31:0] seen, input [31:0] exp, input string nm);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task apb(input wr, input [11:0] a, input [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task tally_and_finish;
      $display("Checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      tally_and_finish;
   end

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      apb(0, `TCM_A_OFFS, 0);
      chk(rd[15:0], 16'h0, "offset default");
      r = $random(seed);
      apb(1, `TCM_A_OFFS, r);
      apb(0, `TCM_A_OFFS, 0);
      chk(rd[15:0], r[15:0], "offset");
      // Offsets go back to zero so the frame check samples the streams unshifted.
      apb(1, `TCM_A_OFFS, 0);
      apb(1, `TCM_A_CTRL, 3);
      apb(0, `TCM_A_CTRL, 0);
      chk(rd[1:0], 2'h3, "control");
      chk(e, 0, "mapped");
      apb(0, 12'h01C, 0);
      chk(e, 1, "unmapped");
      apb(0, 12'hFFC, 0);
      chk(e, 1, "unmapped");
      $display("Test registers done");
      apb(1, `TCM_A_ADDR, 0);
      for (i = 0; i < 128; i++) begin
         r = $random(seed);
         wd = r[15:0] & 16'h79FF;
         if (!wd[13]) wd[6:5] = 2'h0;
         w[i] = wd;
         apb(1, `TCM_A_DATA, wd);
      end
      apb(1, `TCM_A_ADDR, 0);
      for (i = 0; i < 128; i++) begin
         apb(0, `TCM_A_DATA, 0);
         chk(rd[15:0], w[i], "word");
      end
      $display("Test memory done");
      @(posedge clk iff frame_pulse);
      // The frame edge arrives in the high phase, so the latch-edge bit comes out set.
      apb(0, `TCM_A_MEAS, 0);
      chk(rd[11:0], 12'h800, "half cycle flag");
      r = $random(seed);
      apb(1, `TCM_A_OFFS, r & 32'h0000EEEE);
      apb(1, `TCM_A_OFFS_APPLY, 32'h0000000F);
      apb(0, `TCM_A_OFFS, 0);
      chk(rd[15:0], 16'h0000, "applied offset");
      $display("Test measure done");
      @(posedge clk iff frame_pulse);
      repeat (50) @(posedge clk);
      for (k = 0; k < 256; k++) begin
         #1;
         for (s = 0; s < 4; s++) begin
            wd = w[k / 8 * 4 + s];
            by = wd[13] ? wd[7:0] : {wd[8:7], 1'b1, wd[4:0]};
            chk(tx_oe[s], wd[11], "enable");
            if (wd[11]) chk(tx_out[s], by[7 - k % 8], "data");
         end
         if (k % 8 < 4 && k < 248) chk(control_channel_out, w[(k / 8 + 1) * 4 + k % 8][12], "control bit");
         repeat (100) @(posedge clk);
      end
      $display("Test frame done");
      tally_and_finish;
   end
endmodule // tsi_connection_memory_control_test
